// ==== hdl/rivm_top.sv ====
// Reset entry and interrupt vector address generator for the processor core.
// Assumes requests, enables, relocate bit and acknowledge come from logic on
// clk_sys; the boot fuse and boot section start are static straps.
//
// Notes on behaviour
// (R1) Reset entry is word 0x0000 after a reset with the fuse unprogrammed.
// (R2) Vectors two words apart from 0x0002.
// (R3) Timer vectors fill 0x0008 to 0x0016.
// (R4) Serial vectors fill 0x0018 to 0x0022.
// (R5) Remaining vectors fill 0x0024 to 0x0030.
// (R6) Pin-change c and d only in large variant.
// (R7) Programmed fuse moves reset entry to boot start.
// (R8) Relocate bit adds boot start to vectors.
// (R9) Four fuse and relocate combinations as tabled.
// (R10) Unenabled vector slots are never fetched as vectors.
// (R11) Fuse value 1 unprogrammed, 0 programmed.
// (R12) Lowest pending vector number wins.
`timescale 1ns/1ps
`default_nettype none
module rivm_top #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic boot_entry_fuse,
    input wire logic [rivm_pkg::RIVM_ADDR_W-1:0] boot_section_start,
    input wire logic vector_table_relocate,
    input wire logic global_irq_enable,
    input wire logic [rivm_pkg::RIVM_NUM_SOURCES-1:0] irq_request,
    input wire logic [rivm_pkg::RIVM_NUM_SOURCES-1:0] irq_enable,
    input wire logic vector_ack,
    output logic reset_entry_valid,
    output logic [rivm_pkg::RIVM_ADDR_W-1:0] reset_entry_addr,
    output logic vector_valid,
    output rivm_pkg::rivm_vector_t vector_out,
    output logic [rivm_pkg::RIVM_NUM_SOURCES-1:0] source_ack
);
    import rivm_pkg::*;

    rivm_state_t state;
    rivm_state_t next_state;

    logic fuse_latched;
    logic [RIVM_ADDR_W-1:0] boot_start;
    logic [RIVM_NUM_SOURCES-1:0] variant_mask;
    logic [RIVM_NUM_SOURCES-1:0] candidates;
    logic cand_found;
    logic [RIVM_IDX_W-1:0] cand_idx;
    logic [RIVM_ADDR_W-1:0] base_addr;
    logic [RIVM_ADDR_W-1:0] next_vector_addr;
    logic [4:0] next_vector_num;
    logic [RIVM_ADDR_W-1:0] next_reset_addr;
    logic start_present;
    logic take_ack;

    // Absent sources of the small variant can never be raised
    assign variant_mask = LARGE_VARIANT ? '1 : ~RIVM_LARGE_ONLY_MASK; // (R6)

    // Only enabled requests are candidates; a source just acknowledged is
    // masked for one cycle while its own flag clears
    assign candidates = irq_request & irq_enable & variant_mask & ~source_ack; // (R10)

    rivm_prio_enc u_prio_enc (
        .req(candidates),
        .found(cand_found),
        .idx(cand_idx)
    );

    // Table base is two words per source, starting at the first vector
    assign base_addr = RIVM_FIRST_VECTOR_ADDR + {10'h000, cand_idx, 1'b0}; // (R2) (R3) (R4) (R5)

    always_comb begin
        next_vector_addr = base_addr;
        if (vector_table_relocate) begin
            next_vector_addr = base_addr + boot_start; // (R8) (R9)
        end
    end

    assign next_vector_num = RIVM_FIRST_IRQ_VECTOR_NUM + {1'b0, cand_idx[3:0]} +
                             {cand_idx[4], 4'h0};

    always_comb begin
        next_reset_addr = RIVM_RESET_ADDR_DEFAULT; // (R1)
        if (fuse_latched == RIVM_FUSE_PROGRAMMED) begin // (R11)
            next_reset_addr = boot_start; // (R7) (R9)
        end
    end

    assign start_present = (state == RIVM_ST_IDLE) && global_irq_enable && cand_found; // (R10)
    assign take_ack = (state == RIVM_ST_PRESENT) && vector_ack;

    always_comb begin
        next_state = state;
        case (state)
            RIVM_ST_CAPTURE: begin
                next_state = RIVM_ST_RESET_ENTRY;
            end
            RIVM_ST_RESET_ENTRY: begin
                next_state = RIVM_ST_IDLE;
            end
            RIVM_ST_IDLE: begin
                if (start_present) begin
                    next_state = RIVM_ST_PRESENT;
                end
            end
            RIVM_ST_PRESENT: begin
                if (vector_ack) begin
                    next_state = RIVM_ST_IDLE;
                end
            end
            default: begin
                next_state = RIVM_ST_CAPTURE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= RIVM_ST_CAPTURE;
        end else begin
            state <= next_state;
        end
    end

    // Straps are caught on the first edge after reset release
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fuse_latched <= RIVM_FUSE_UNPROGRAMMED;
            boot_start <= RIVM_BOOT_START_RESET;
        end else if (state == RIVM_ST_CAPTURE) begin
            fuse_latched <= boot_entry_fuse; // (R11)
            boot_start <= boot_section_start;
        end
    end

    // One-cycle reset entry announcement; address then stays stable
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reset_entry_valid <= 1'b0;
            reset_entry_addr <= RIVM_RESET_ADDR_DEFAULT;
        end else begin
            reset_entry_valid <= (state == RIVM_ST_RESET_ENTRY); // (R1)
            if (state == RIVM_ST_RESET_ENTRY) begin
                reset_entry_addr <= next_reset_addr; // (R7)
            end
        end
    end

    // Vector is frozen while presented so a late higher request waits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vector_valid <= 1'b0;
            vector_out <= '0;
        end else if (start_present) begin
            vector_valid <= 1'b1;
            vector_out.num <= next_vector_num;
            vector_out.addr <= next_vector_addr; // (R12)
        end else if (take_ack) begin
            vector_valid <= 1'b0;
        end
    end

    // Acknowledge pulse to the source whose vector was taken
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            source_ack <= '0;
        end else begin
            source_ack <= '0;
            if (take_ack) begin
                source_ack[vector_out.num - RIVM_FIRST_IRQ_VECTOR_NUM] <= 1'b1;
            end
        end
    end
endmodule // rivm_top
`default_nettype wire

// ==== hdl/rivm_pkg.sv ====
// Constants, types and vector layout for the reset and interrupt vector map.
// Assumes a 16-bit program word address space and one system clock.
package rivm_pkg;
    localparam int unsigned RIVM_NUM_SOURCES = 24;
    localparam int unsigned RIVM_IDX_W = 5;
    localparam int unsigned RIVM_ADDR_W = 16;

    // Program word addresses
    localparam logic [15:0] RIVM_RESET_ADDR_DEFAULT = 16'h0000;
    localparam logic [15:0] RIVM_FIRST_VECTOR_ADDR = 16'h0002;
    localparam logic [15:0] RIVM_LAST_VECTOR_ADDR = 16'h0030;
    localparam logic [15:0] RIVM_BOOT_START_RESET = 16'h0000;

    // Vector number of the reset entry; source index i has vector i + 2
    localparam logic [4:0] RIVM_RESET_VECTOR_NUM = 5'h01;
    localparam logic [4:0] RIVM_FIRST_IRQ_VECTOR_NUM = 5'h02;

    // Boot-entry fuse encoding
    localparam logic RIVM_FUSE_PROGRAMMED = 1'b0;
    localparam logic RIVM_FUSE_UNPROGRAMMED = 1'b1;

    // Source indices (request bit positions), lowest index is highest priority
    localparam int unsigned RIVM_SRC_EXT_REQ_ZERO = 0;
    localparam int unsigned RIVM_SRC_PIN_CHANGE_A = 1;
    localparam int unsigned RIVM_SRC_PIN_CHANGE_B = 2;
    localparam int unsigned RIVM_SRC_TIMER2_COMP = 3;
    localparam int unsigned RIVM_SRC_TIMER2_OVF = 4;
    localparam int unsigned RIVM_SRC_TIMER1_CAPT = 5;
    localparam int unsigned RIVM_SRC_TIMER1_COMPA = 6;
    localparam int unsigned RIVM_SRC_TIMER1_COMPB = 7;
    localparam int unsigned RIVM_SRC_TIMER1_OVF = 8;
    localparam int unsigned RIVM_SRC_TIMER0_COMP = 9;
    localparam int unsigned RIVM_SRC_TIMER0_OVF = 10;
    localparam int unsigned RIVM_SRC_SPI_DONE = 11;
    localparam int unsigned RIVM_SRC_USART_RX = 12;
    localparam int unsigned RIVM_SRC_USART_EMPTY = 13;
    localparam int unsigned RIVM_SRC_USART_TX = 14;
    localparam int unsigned RIVM_SRC_USI_START = 15;
    localparam int unsigned RIVM_SRC_USI_OVF = 16;
    localparam int unsigned RIVM_SRC_ANALOG_COMP = 17;
    localparam int unsigned RIVM_SRC_ADC_DONE = 18;
    localparam int unsigned RIVM_SRC_EEPROM_READY = 19;
    localparam int unsigned RIVM_SRC_SPM_READY = 20;
    localparam int unsigned RIVM_SRC_LCD_FRAME = 21;
    localparam int unsigned RIVM_SRC_PIN_CHANGE_C = 22;
    localparam int unsigned RIVM_SRC_PIN_CHANGE_D = 23;

    // Sources that exist only in the larger pin-count variant
    localparam logic [23:0] RIVM_LARGE_ONLY_MASK = 24'hC00000;

    typedef enum logic [1:0] {
        RIVM_ST_CAPTURE = 2'b00,
        RIVM_ST_RESET_ENTRY = 2'b01,
        RIVM_ST_IDLE = 2'b10,
        RIVM_ST_PRESENT = 2'b11
    } rivm_state_t;

    typedef struct packed {
        logic [4:0] num;
        logic [15:0] addr;
    } rivm_vector_t;
endpackage

// ==== hdl/rivm_prio_enc.sv ====
// Fixed-priority encoder: finds the lowest set request bit.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module rivm_prio_enc (
    input wire logic [rivm_pkg::RIVM_NUM_SOURCES-1:0] req,
    output logic found,
    output logic [rivm_pkg::RIVM_IDX_W-1:0] idx
);
    import rivm_pkg::*;

    logic [RIVM_NUM_SOURCES:0] lower_any;
    logic [RIVM_IDX_W-1:0] partial [RIVM_NUM_SOURCES+1];

    assign lower_any[0] = 1'b0;
    assign partial[0] = '0;

    genvar i;
    generate
        for (i = 0; i < RIVM_NUM_SOURCES; i = i + 1) begin : g_bit
            logic hit;
            assign hit = req[i] & ~lower_any[i];
            assign lower_any[i+1] = lower_any[i] | req[i];
            assign partial[i+1] = partial[i] | (hit ? RIVM_IDX_W'(i) : '0); // (R12)
        end
    endgenerate

    assign found = lower_any[RIVM_NUM_SOURCES];
    assign idx = partial[RIVM_NUM_SOURCES];
endmodule // rivm_prio_enc
`default_nettype wire

// ==== verif/rivm_monitor.sv ====
// Port checker for the reset entry and vector map.
// Assumes straps change only while rst is high.
`timescale 1ns/1ps
`default_nettype none
module rivm_monitor #(
    parameter bit LARGE_VARIANT = 1'h1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic boot_entry_fuse,
    input wire logic [15:0] boot_section_start,
    input wire logic vector_table_relocate,
    input wire logic global_irq_enable,
    input wire logic [23:0] irq_request,
    input wire logic [23:0] irq_enable,
    input wire logic vector_ack,
    input wire logic reset_entry_valid,
    input wire logic [15:0] reset_entry_addr,
    input wire logic vector_valid,
    input wire rivm_pkg::rivm_vector_t vector_out,
    input wire logic [23:0] source_ack
);
    import rivm_pkg::*;
    logic [23:0] sel;
    logic [23:0] took;
    assign sel = 24'h1 << (vector_out.num - 5'h2);
    // Source whose vector the core took last
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            took <= 24'h0;
        else if (vector_valid && vector_ack)
            took <= sel;
    end
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    property p_entry_pulse; reset_entry_valid |=> !reset_entry_valid; endproperty
    a_entry_pulse: assert property (p_entry_pulse) else $error("entry pulse too long");
    property p_entry_addr; reset_entry_valid |->
        reset_entry_addr == (boot_entry_fuse ? 16'h0 : boot_section_start); endproperty
    a_entry_addr: assert property (p_entry_addr) else $error("bad entry address");
    property p_vec_addr; $rose(vector_valid) |-> vector_out.addr == 16'h2
        + {10'h0, vector_out.num - 5'h2, 1'h0}
        + ($past(vector_table_relocate) ? boot_section_start : 16'h0); endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("bad vector address");
    property p_variant; vector_valid |->
        vector_out.num >= 5'h2 && vector_out.num <= (LARGE_VARIANT ? 5'h19 : 5'h17); endproperty
    a_variant: assert property (p_variant) else $error("vector number out of range");
    property p_hold; vector_valid && !vector_ack |=> vector_valid && $stable(vector_out);
    endproperty
    a_hold: assert property (p_hold) else $error("vector changed before ack");
    property p_drop; vector_valid && vector_ack |=> !vector_valid; endproperty
    a_drop: assert property (p_drop) else $error("vector kept after ack");
    property p_src; |source_ack |-> $onehot(source_ack) && source_ack == took; endproperty
    a_src: assert property (p_src) else $error("wrong source acknowledged");
    property p_prio; $rose(vector_valid) |->
        ($past(irq_request & irq_enable & ~source_ack) & (sel - 24'h1)) == 24'h0; endproperty
    a_prio: assert property (p_prio) else $error("lower vector pending");
    property p_enabled; $rose(vector_valid) |->
        $past(global_irq_enable) && (|($past(irq_request & irq_enable) & sel)); endproperty
    a_enabled: assert property (p_enabled) else $error("vector without request");
endmodule // rivm_monitor
bind rivm_top rivm_monitor #(.LARGE_VARIANT(LARGE_VARIANT)) u_mon (.*);
`default_nettype wire

// ==== verif/rivm_core_model.sv ====
// Core model: takes each presented vector after a chosen wait.
// Assumes vector_valid holds until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module rivm_core_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic vector_valid,
    input wire logic [1:0] wait_cycles,
    output logic vector_ack
);
    logic [1:0] cnt;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
            vector_ack <= 1'h0;
        end else if (vector_valid && !vector_ack) begin
            cnt <= cnt + 2'h1;
            vector_ack <= (cnt == wait_cycles);
        end else begin
            cnt <= 2'h0;
            vector_ack <= 1'h0;
        end
    end
endmodule // rivm_core_model
`default_nettype wire

// ==== verif/tb.sv ====
// Bench: reset entries, every source, random priority mixes.
// Assumes the core model acks; the bench plays the peripherals.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rivm_pkg::*;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic boot_entry_fuse = 1'h1;
    logic [15:0] boot_section_start = 16'h0;
    logic vector_table_relocate = 1'h0;
    logic global_irq_enable = 1'h0;
    logic [23:0] irq_request = 24'h0;
    logic [23:0] irq_enable = 24'h0;
    logic [1:0] dly = 2'h0;
    logic vector_ack, reset_entry_valid, vector_valid;
    logic [15:0] reset_entry_addr;
    rivm_vector_t vector_out;
    logic [23:0] source_ack;
    int fail_count = 0;
    int compares = 0;
    rivm_top dut (.*);
    rivm_core_model core (.*, .wait_cycles(dly));
    // Small variant beside the large one: same traffic, never pin-change c or d
    logic vector_ack_small, reset_entry_valid_small, vector_valid_small;
    logic [15:0] reset_entry_addr_small;
    rivm_vector_t vector_out_small;
    logic [23:0] source_ack_small;
    logic small_bad = 1'h0;
    rivm_top #(.LARGE_VARIANT(1'b0)) dut_small (
        .clk_sys(clk_sys),
        .rst(rst),
        .boot_entry_fuse(boot_entry_fuse),
        .boot_section_start(boot_section_start),
        .vector_table_relocate(vector_table_relocate),
        .global_irq_enable(global_irq_enable),
        .irq_request(irq_request),
        .irq_enable(irq_enable),
        .vector_ack(vector_ack_small),
        .reset_entry_valid(reset_entry_valid_small),
        .reset_entry_addr(reset_entry_addr_small),
        .vector_valid(vector_valid_small),
        .vector_out(vector_out_small),
        .source_ack(source_ack_small)
    );
    rivm_core_model core_small (
        .clk_sys(clk_sys),
        .rst(rst),
        .vector_valid(vector_valid_small),
        .wait_cycles(dly),
        .vector_ack(vector_ack_small)
    );
    // Small variant must track the large one except for vectors 24 and 25
    always @(posedge clk_sys) begin
        if (!rst && (vector_valid_small !== (vector_valid && vector_out.num < 5'h18)
                || source_ack_small !== (source_ack & ~RIVM_LARGE_ONLY_MASK)
                || reset_entry_valid_small !== reset_entry_valid
                || reset_entry_addr_small !== reset_entry_addr
                || (vector_valid_small && vector_out_small !== vector_out))) begin
            small_bad <= 1'h1;
        end
    end
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(inout int n);
        @(posedge clk_sys);
        #1;
        n++;
        if (n > 60) begin
            fail_count++;
            stop_test;
        end
    endtask
    function automatic logic [23:0] exp_vec(input logic [4:0] k, input logic r);
        return {3'h0, k + 5'h2, 16'h2 + {10'h0, k, 1'h0} + (r ? boot_section_start : 16'h0)};
    endfunction
    task automatic do_reset(input logic f, input logic [15:0] b);
        int n;
        n = 0;
        @(posedge clk_sys);
        rst <= 1'h1;
        boot_entry_fuse <= f;
        boot_section_start <= b;
        repeat (20) @(posedge clk_sys);
        rst <= 1'h0;
        while (reset_entry_valid !== 1'h1)
            tick(n);
        chk(24'(n), 24'h2);
        chk(24'(reset_entry_addr), 24'(f ? 16'h0 : b));
        tick(n);
        chk(24'(reset_entry_valid), 24'h0);
    endtask
    // Peripherals drop a request once its vector was taken
    task automatic serve(input logic [23:0] r, input logic [23:0] e, input logic rl);
        logic [23:0] left;
        logic [4:0] k;
        int n;
        @(posedge clk_sys);
        irq_request <= r;
        irq_enable <= e;
        vector_table_relocate <= rl;
        dly <= 2'($urandom);
        left = r & e;
        while (left != 24'h0) begin
            n = 0;
            while (vector_valid !== 1'h1)
                tick(n);
            for (int i = 23; i >= 0; i--)
                if (left[i])
                    k = 5'(i);
            chk(24'(vector_out), exp_vec(k, rl));
            while (source_ack === 24'h0)
                tick(n);
            chk(source_ack, 24'h1 << k);
            left[k] = 1'h0;
            @(posedge clk_sys);
            irq_request <= irq_request & ~(24'h1 << k);
            #1;
        end
        repeat (4) @(posedge clk_sys);
        #1;
        chk(24'(vector_valid), 24'h0);
    endtask
    initial begin
        void'($urandom(32'hAF55));
        do_reset(1'h1, 16'h3800);
        @(posedge clk_sys);
        irq_request <= 24'hFFFFFF;
        irq_enable <= 24'hFFFFFF;
        repeat (5) @(posedge clk_sys);
        #1;
        chk(24'(vector_valid), 24'h0);
        @(posedge clk_sys);
        irq_request <= 24'h0;
        global_irq_enable <= 1'h1;
        for (int i = 0; i < 24; i++)
            serve(24'h1 << i, 24'hFFFFFF, 1'(i));
        serve(24'hFFFFFF, 24'hFFFFFF, 1'h1);
        do_reset(1'h0, 16'h7800);
        repeat (12)
            serve(24'($urandom), 24'($urandom), 1'($urandom));
        chk(24'(small_bad), 24'h0);
        stop_test;
    end
endmodule // tb
`default_nettype wire
